// [wide_vector_state_consts.svh]
// Offsets, field positions, reset values and query codes of the extended state enable logic.
// Assumes inclusion by bare name from every file that needs these numbers.
`ifndef WIDE_VECTOR_STATE_CONSTS_SVH
`define WIDE_VECTOR_STATE_CONSTS_SVH

// State component enable register
`define SCE_RESET 64'h0000_0000_0000_0001
`define SCE_X87_BIT 0
`define SCE_NARROW_BIT 1
`define SCE_WIDE_BIT 2
`define SCE_SUPPORT_DEFAULT 64'h0000_0000_0000_0007

// Control register 4 field positions
`define CR4_LEGACY_SAVE_BIT 9
`define CR4_VEC_FP_EXC_BIT 10
`define CR4_EXT_STATE_BIT 18

// Processor-ID query leaves and flag positions
`define LEAF_BASIC 32'h0000_0001
`define LEAF_EXT_STATE 32'h0000_000D
`define SUBLEAF_MAIN 32'h0000_0000
`define SUBLEAF_WIDE 32'h0000_0002
`define ID1_SAVE_SUPPORT_BIT 26
`define ID1_OS_ALLOW_BIT 27

// Save area layout, byte offsets and sizes
`define LEGACY_AREA_OFF 16'h0000
`define LEGACY_AREA_SIZE 16'h0200
`define HDR_OFF 16'h0200
`define HDR_SIZE 16'h0040
`define HDR_RSVD_OFF 16'h0210
`define WIDE_AREA_OFF 16'h0240
`define WIDE_AREA_SIZE 16'h0100
`define WIDE_PAIR_STRIDE 16'h0020
`define WIDE_HALF_SIZE 16'h0010

// Fault error code
`define GP_ERR_CODE 16'h0000

`endif

// [wide_vector_state_pkg.sv]
// Types shared by the extended state enable block and its register file.
// Assumes nothing beyond a SystemVerilog compiler.
package wide_vector_state_pkg;

  typedef enum logic [3:0] {
    CLS_NONE = 4'b0000,
    CLS_WIDE_256 = 4'b0001,
    CLS_WIDE_128 = 4'b0010,
    CLS_NARROW_LEGACY = 4'b0011,
    CLS_WRITE_ENABLE = 4'b0100,
    CLS_READ_ENABLE = 4'b0101,
    CLS_STATE_SAVE = 4'b0110,
    CLS_STATE_RESTORE = 4'b0111,
    CLS_ID_QUERY = 4'b1000
  } instr_class_t;

  typedef struct packed {
    instr_class_t cls;
    logic fp_exc;
    logic [63:0] operand;
    logic [31:0] leaf;
    logic [31:0] subleaf;
    logic [63:0] hdr_bv;
    logic [191:0] hdr_rsvd;
  } check_req_t;

  typedef struct packed {
    logic done;
    logic ud;
    logic gp;
    logic simd_exc;
    logic [15:0] err_code;
    logic [63:0] data;
    logic [31:0] eax;
    logic [31:0] ebx;
    logic [31:0] ecx;
    logic [31:0] edx;
  } check_resp_t;

  typedef struct packed {
    logic we;
    logic wide;
    logic zero_upper;
    logic [3:0] idx;
    logic [255:0] data;
  } vreg_req_t;

endpackage : wide_vector_state_pkg

// [wide_vector_regfile.sv]
// Sixteen wide vector registers whose low halves are the narrow registers.
// Assumes one write and one read per cycle from logic on clk_sys.
`timescale 1ns/100ps
module wide_vector_regfile #(
  parameter int NUM_REGS = 16,
  parameter int LANE = 128
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Access
  input wire wide_vector_state_pkg::vreg_req_t vreq,
  input wire logic [3:0] rd_idx,
  output logic [2*LANE-1:0] rdata_r
);

  // One storage array per half; the narrow name writes the low half and zeroes the high half when zero_upper is set
  logic [LANE-1:0] lo_mem [NUM_REGS];
  logic [LANE-1:0] hi_mem [NUM_REGS];
  logic [2*LANE-1:0] rdata_nxt;
  logic [LANE-1:0] hi_wdata;
  logic hi_we;

  always_comb begin
    rdata_nxt = {hi_mem[rd_idx], lo_mem[rd_idx]};
    hi_we = vreq.we && (vreq.wide || vreq.zero_upper);
    hi_wdata = vreq.wide ? vreq.data[2*LANE-1:LANE] : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (vreq.we) begin
      lo_mem[vreq.idx] <= vreq.data[LANE-1:0];
    end
    if (hi_we) begin
      hi_mem[vreq.idx] <= hi_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  chk_alias_low_half: assert property (@(posedge clk_sys) disable iff (rst)
    (vreq.we && !vreq.wide) ##1 (rd_idx == $past(vreq.idx) && !vreq.we)
    |=> rdata_r[LANE-1:0] == $past(vreq.data[LANE-1:0], 2))
    else $error("narrow write not visible through wide register");

endmodule : wide_vector_regfile

// [wide_vector_state_enable_layout.sv]
// Extended state enable register, instruction gating faults, id query answers and save layout.
// Assumes control register 4 and all requests come from logic on clk_sys; answers follow one cycle later.
//
// How it works
// - Without wide state enabled, every wide extension instruction, 128-bit ones too, faults undefined.
// - Query leaf 0DH subleaf 0 returns the 64-bit support vector in EDX:EAX.
// - Query leaf 1 reports save support in ECX bit 26.
// - Control register 4 bit 18 must be set before enable register access.
// - Enable write with bits 2:1 equal 10B faults protection with code 0.
// - Enable bit 0 always 1; bits 1 and 2 needed for wide; 63:3 zero.
// - Control register 4 bit 10 gates vector float exceptions, wide and narrow alike.
// - Bit 9 ignored by wide instructions, required by narrow vector instructions.
// - Low 128 bits of each wide register are the narrow register.
// - Save area opens with 512-byte legacy image, then 64-byte header at 512.
// - Header bytes 7:0 hold saved component vector; bytes 16 to 39 must be zero.
// - Wide upper halves start at 576, two per 32 bytes, reported by subleaf 2.
// - Enable write clearing bit 0 faults protection and leaves the register unchanged.
// - Control register 4 bit 18 is mirrored into leaf 1 ECX bit 27.
`timescale 1ns/100ps
`include "wide_vector_state_consts.svh"
module wide_vector_state_enable_layout #(
  parameter logic [63:0] SUPPORT_MASK = `SCE_SUPPORT_DEFAULT,
  parameter int NUM_REGS = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control register 4 as held by the core
  input wire logic [31:0] control_register_4,
  // Instruction check request and answer
  input wire logic req_valid,
  input wire wide_vector_state_pkg::check_req_t req,
  output wide_vector_state_pkg::check_resp_t resp_r,
  // Current enable register
  output logic [63:0] state_component_enable_r,
  // Vector register access
  input wire wide_vector_state_pkg::vreg_req_t vreq,
  input wire logic [3:0] vreg_rd_idx,
  output logic [255:0] vreg_rdata_r,
  // Save area layout lookup
  input wire logic [3:0] lay_idx,
  output logic [15:0] lay_off_r
);

  localparam logic [31:0] SAVE_SIZE_FULL = {16'h0000, `WIDE_AREA_OFF + `WIDE_AREA_SIZE};
  localparam logic [31:0] SAVE_SIZE_BASE = {16'h0000, `HDR_OFF + `HDR_SIZE};

  wide_vector_state_pkg::check_resp_t resp_nxt;
  logic [63:0] enable_nxt;
  logic [15:0] lay_off_nxt;
  logic ext_allow;
  logic fp_allow;
  logic legacy_allow;
  logic wide_on;
  logic [1:0] fp_out;

  // Byte offset in the save area of the upper half of wide register idx
  function automatic logic [15:0] wide_upper_off(input logic [3:0] idx);
    logic [15:0] pair;
    pair = {13'h0000, idx[3:1]};
    return `WIDE_AREA_OFF + 16'(pair * `WIDE_PAIR_STRIDE) + (idx[0] ? `WIDE_HALF_SIZE : 16'h0000);
  endfunction : wide_upper_off

  // Bit 0 kept, no wide without narrow, nothing outside the support vector
  function automatic logic write_illegal(input logic [63:0] v, input logic [63:0] support);
    return !v[`SCE_X87_BIT] || (v[`SCE_WIDE_BIT:`SCE_NARROW_BIT] == 2'b10) || (|v[63:3]) || (|(v & ~support));
  endfunction : write_illegal

  // Outcome of a raised vector float exception: {undefined, delivered}
  function automatic logic [1:0] fp_outcome(input logic exc, input logic allow);
    return exc ? (allow ? 2'b01 : 2'b10) : 2'b00;
  endfunction : fp_outcome

  always_comb begin
    ext_allow = control_register_4[`CR4_EXT_STATE_BIT];
    fp_allow = control_register_4[`CR4_VEC_FP_EXC_BIT];
    legacy_allow = control_register_4[`CR4_LEGACY_SAVE_BIT];
    wide_on = ext_allow && state_component_enable_r[`SCE_WIDE_BIT] && state_component_enable_r[`SCE_NARROW_BIT];
    fp_out = fp_outcome(req.fp_exc, fp_allow);
  end

  always_comb begin
    enable_nxt = state_component_enable_r;
    resp_nxt = '0;
    lay_off_nxt = wide_upper_off(lay_idx);
    if (req_valid) begin
      resp_nxt.done = 1'b1;
      resp_nxt.err_code = `GP_ERR_CODE;
      case (req.cls)
        wide_vector_state_pkg::CLS_WIDE_256, wide_vector_state_pkg::CLS_WIDE_128: begin
          // Bit 9 plays no part for the wide forms
          if (!wide_on) begin
            resp_nxt.ud = 1'b1;
          end else begin
            resp_nxt.ud = fp_out[1];
            resp_nxt.simd_exc = fp_out[0];
          end
        end
        wide_vector_state_pkg::CLS_NARROW_LEGACY: begin
          if (!legacy_allow) begin
            resp_nxt.ud = 1'b1;
          end else begin
            resp_nxt.ud = fp_out[1];
            resp_nxt.simd_exc = fp_out[0];
          end
        end
        wide_vector_state_pkg::CLS_WRITE_ENABLE: begin
          if (!ext_allow) begin
            resp_nxt.ud = 1'b1;
          end else if (write_illegal(req.operand, SUPPORT_MASK)) begin
            resp_nxt.gp = 1'b1;
          end else begin
            enable_nxt = req.operand;
          end
        end
        wide_vector_state_pkg::CLS_READ_ENABLE: begin
          if (!ext_allow) begin
            resp_nxt.ud = 1'b1;
          end else begin
            resp_nxt.data = state_component_enable_r;
          end
        end
        wide_vector_state_pkg::CLS_STATE_SAVE: begin
          // Answer is the saved component vector for header bytes 7:0
          if (!ext_allow) begin
            resp_nxt.ud = 1'b1;
          end else begin
            resp_nxt.data = state_component_enable_r & req.operand;
          end
        end
        wide_vector_state_pkg::CLS_STATE_RESTORE: begin
          // A stored header with dirty reserved bytes or foreign components is refused
          if (!ext_allow) begin
            resp_nxt.ud = 1'b1;
          end else if ((|req.hdr_rsvd) || (|(req.hdr_bv & ~state_component_enable_r))) begin
            resp_nxt.gp = 1'b1;
          end else begin
            resp_nxt.data = req.hdr_bv & req.operand & state_component_enable_r;
          end
        end
        wide_vector_state_pkg::CLS_ID_QUERY: begin
          if (req.leaf == `LEAF_BASIC) begin
            resp_nxt.ecx[`ID1_SAVE_SUPPORT_BIT] = 1'b1;
            resp_nxt.ecx[`ID1_OS_ALLOW_BIT] = ext_allow;
          end else if (req.leaf == `LEAF_EXT_STATE && req.subleaf == `SUBLEAF_MAIN) begin
            resp_nxt.eax = SUPPORT_MASK[31:0];
            resp_nxt.edx = SUPPORT_MASK[63:32];
            resp_nxt.ecx = SAVE_SIZE_FULL;
            resp_nxt.ebx = state_component_enable_r[`SCE_WIDE_BIT] ? SAVE_SIZE_FULL : SAVE_SIZE_BASE;
          end else if (req.leaf == `LEAF_EXT_STATE && req.subleaf == `SUBLEAF_WIDE) begin
            resp_nxt.eax = {16'h0000, `WIDE_AREA_SIZE};
            resp_nxt.ebx = {16'h0000, `WIDE_AREA_OFF};
          end
        end
        default: begin
          resp_nxt.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_component_enable_r <= `SCE_RESET;
      resp_r <= '0;
      lay_off_r <= 16'h0000;
    end else begin
      state_component_enable_r <= enable_nxt;
      resp_r <= resp_nxt;
      lay_off_r <= lay_off_nxt;
    end
  end

  wide_vector_regfile #(
    .NUM_REGS(NUM_REGS),
    .LANE(128)
  ) u_regfile (
    .clk_sys(clk_sys),
    .rst(rst),
    .vreq(vreq),
    .rd_idx(vreg_rd_idx),
    .rdata_r(vreg_rdata_r)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_wide_ud_off: assert property (
    req_valid && (req.cls == wide_vector_state_pkg::CLS_WIDE_128) && !wide_on |=> resp_r.done && resp_r.ud)
    else $error("wide instruction ran without state enabled");

  chk_support_vector: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_ID_QUERY && req.leaf == 32'h0000_000D
      && req.subleaf == 32'h0000_0000 |=> {resp_r.edx, resp_r.eax} == SUPPORT_MASK)
    else $error("support vector wrong");

  chk_leaf1_support: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_ID_QUERY && req.leaf == 32'h0000_0001
      |=> resp_r.ecx[26])
    else $error("save support flag missing");

  chk_write_gated: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WRITE_ENABLE && !control_register_4[18]
      |=> resp_r.ud && $stable(state_component_enable_r))
    else $error("enable write taken while disallowed");

  chk_bad_pair_gp: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WRITE_ENABLE && control_register_4[18]
      && req.operand[2:1] == 2'b10 |=> resp_r.gp && resp_r.err_code == 16'h0000)
    else $error("wide without narrow not refused");

  chk_x87_held: assert property (state_component_enable_r[0] && state_component_enable_r[63:3] == '0)
    else $error("enable register lost bit 0 or holds reserved bits");

  chk_x87_clear_gp: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WRITE_ENABLE && control_register_4[18]
      && !req.operand[0] |=> resp_r.gp && state_component_enable_r == $past(state_component_enable_r))
    else $error("bit 0 clear accepted");

  chk_fp_exc_gate: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_NARROW_LEGACY && control_register_4[9]
      && req.fp_exc |=> resp_r.simd_exc == $past(control_register_4[10]) && resp_r.ud != resp_r.simd_exc)
    else $error("vector float exception misrouted");

  chk_legacy_gate: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WIDE_256 && wide_on && !req.fp_exc
      && !control_register_4[9] |=> !resp_r.ud)
    else $error("bit 9 wrongly gates wide instruction");

  chk_os_mirror: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_ID_QUERY && req.leaf == 32'h0000_0001
      ##1 resp_r.done |-> resp_r.ecx[27] == $past(control_register_4[18]))
    else $error("mirror bit wrong");

  chk_last_offset: assert property (lay_idx == 4'hF |=> lay_off_r == 16'h0330)
    else $error("upper half of last register misplaced");

  chk_save_size: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_ID_QUERY && req.leaf == 32'h0000_000D
      && req.subleaf == 32'h0000_0000 |=> resp_r.ecx == 32'h0000_0340)
    else $error("save area size wrong");

  chk_reserved_gp: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WRITE_ENABLE && control_register_4[18]
      && (|req.operand[63:3]) |=> resp_r.gp ##1 1'b1)
    else $error("reserved enable bit accepted");

  chk_w256_ud_off: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WIDE_256 && !wide_on
      |=> resp_r.done && resp_r.ud && !resp_r.simd_exc)
    else $error("256-bit wide instruction ran without state enabled");

  chk_wide_allowed: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WIDE_128 && wide_on && !req.fp_exc
      |=> resp_r.done && !resp_r.ud)
    else $error("enabled wide instruction faulted");

  chk_read_gated: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_READ_ENABLE && !control_register_4[18]
      |=> resp_r.ud && resp_r.data == '0)
    else $error("enable read taken while disallowed");

  chk_read_value: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_READ_ENABLE && control_register_4[18]
      |=> !resp_r.ud && resp_r.data == $past(state_component_enable_r))
    else $error("enable read returned wrong value");

  chk_full_enable: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_WRITE_ENABLE && control_register_4[18]
      && req.operand == 64'h0000_0000_0000_0007 && SUPPORT_MASK[2:0] == 3'h7
      |=> !resp_r.gp && state_component_enable_r == 64'h0000_0000_0000_0007)
    else $error("legal full enable write refused");

  chk_fp_wide_gate: assert property (
    req_valid && (req.cls == wide_vector_state_pkg::CLS_WIDE_256 || req.cls == wide_vector_state_pkg::CLS_WIDE_128)
      && wide_on && req.fp_exc
      |=> resp_r.simd_exc == $past(control_register_4[10]) && resp_r.ud != resp_r.simd_exc)
    else $error("wide vector float exception misrouted");

  chk_narrow_gate: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_NARROW_LEGACY && !control_register_4[9]
      |=> resp_r.done && resp_r.ud && !resp_r.simd_exc)
    else $error("narrow vector instruction ran with legacy save off");

  chk_save_vector: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_STATE_SAVE && control_register_4[18]
      |=> resp_r.data == ($past(state_component_enable_r) & $past(req.operand)))
    else $error("saved component vector wrong");

  chk_restore_rsvd: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_STATE_RESTORE && control_register_4[18]
      && (|req.hdr_rsvd) |=> resp_r.gp && !resp_r.ud)
    else $error("dirty reserved header bytes accepted");

  chk_wide_area_query: assert property (
    req_valid && req.cls == wide_vector_state_pkg::CLS_ID_QUERY && req.leaf == 32'h0000_000D
      && req.subleaf == 32'h0000_0002 |=> resp_r.eax == 32'h0000_0100 && resp_r.ebx == 32'h0000_0240)
    else $error("wide area offset or size wrong");

  chk_first_offset: assert property (lay_idx == 4'h0 |=> lay_off_r == 16'h0240)
    else $error("upper half of first register misplaced");

endmodule : wide_vector_state_enable_layout

// [wide_vector_state_enable_layout_tb.sv]
// Self-checking bench for the enable register, instruction gating, id query answers and save layout.
// Assumes answers one cycle after each taken request; the bench drives every input on falling edges.
`timescale 1ns/100ps
module wide_vector_state_enable_layout_tb;
  localparam wide_vector_state_pkg::instr_class_t W256 = wide_vector_state_pkg::CLS_WIDE_256;
  localparam wide_vector_state_pkg::instr_class_t W128 = wide_vector_state_pkg::CLS_WIDE_128;
  localparam wide_vector_state_pkg::instr_class_t NAR = wide_vector_state_pkg::CLS_NARROW_LEGACY;
  localparam wide_vector_state_pkg::instr_class_t WR = wide_vector_state_pkg::CLS_WRITE_ENABLE;
  localparam wide_vector_state_pkg::instr_class_t RD = wide_vector_state_pkg::CLS_READ_ENABLE;
  localparam wide_vector_state_pkg::instr_class_t SV = wide_vector_state_pkg::CLS_STATE_SAVE;
  localparam wide_vector_state_pkg::instr_class_t RS = wide_vector_state_pkg::CLS_STATE_RESTORE;
  localparam wide_vector_state_pkg::instr_class_t ID = wide_vector_state_pkg::CLS_ID_QUERY;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] control_register_4 = 32'h0;
  logic req_valid = 1'b0;
  wide_vector_state_pkg::check_req_t req = '0;
  wide_vector_state_pkg::check_resp_t resp_r;
  logic [63:0] state_component_enable_r;
  wide_vector_state_pkg::vreg_req_t vreq = '0;
  logic [3:0] vreg_rd_idx = 4'h0;
  logic [255:0] vreg_rdata_r;
  logic [3:0] lay_idx = 4'h0;
  logic [15:0] lay_off_r;
  int miscompares = 0;
  int tests_run = 0;
  logic [63:0] en_m = 64'h1;
  logic [255:0] vm [16];
  logic [255:0] rv;
  logic [31:0] cr4_tab [4] = '{32'h0004_0000, 32'h0004_0400, 32'h0004_0200, 32'h0004_0600};
  logic [63:0] wr_tab [6] = '{64'h5, 64'h6, 64'h8, 64'h8000_0000_0000_0007, 64'h3, 64'h7};

  always #2.5 clk_sys = ~clk_sys;

  wide_vector_state_enable_layout i_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .control_register_4(control_register_4),
    .req_valid(req_valid),
    .req(req),
    .resp_r(resp_r),
    .state_component_enable_r(state_component_enable_r),
    .vreq(vreq),
    .vreg_rd_idx(vreg_rd_idx),
    .vreg_rdata_r(vreg_rdata_r),
    .lay_idx(lay_idx),
    .lay_off_r(lay_off_r)
  );

  task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // One request; the model works out flags, data and the new enable value from the state before it
  task automatic run(input wide_vector_state_pkg::instr_class_t c, input logic [63:0] op, input logic [31:0] lf,
                     input logic [31:0] sb, input logic fp, input logic [191:0] rs);
    logic [3:0] ef;
    logic [63:0] ed;
    logic [63:0] en_old;
    logic ok;
    ef = 4'b1000;
    ed = 64'h0;
    en_old = en_m;
    ok = control_register_4[18];
    case (c)
      W256, W128, NAR: begin
        ok = (c == NAR) ? control_register_4[9] : (ok && en_m[2] && en_m[1]);
        ef[2] = !ok || (fp && !control_register_4[10]);
        ef[0] = ok && fp && control_register_4[10];
      end
      WR: begin
        ef[2] = !ok;
        ef[1] = ok && !(op[0] && op[2:1] != 2'b10 && op[63:3] == 61'h0);
        if (ok && !ef[1]) en_m = op;
      end
      RD, SV: begin
        ef[2] = !ok;
        ed = (c == RD) ? en_m : (en_m & op);
      end
      RS: begin
        ef[2] = !ok;
        ef[1] = ok && (rs != 192'h0 || (op & ~en_m) != 64'h0);
        ed = op & en_m;
      end
      ID: ;
      default: ef[3] = 1'b0;
    endcase
    req_valid = 1'b1;
    req = {c, fp, op, lf, sb, op, rs};
    @(negedge clk_sys);
    chk("flags", ef, {resp_r.done, resp_r.ud, resp_r.gp, resp_r.simd_exc});
    if (ef[1]) chk("err_code", 16'h0000, resp_r.err_code);
    if (ef[2:1] == 2'b00 && (c == RD || c == SV || c == RS)) chk("data", ed, resp_r.data);
    chk("enable", en_m, state_component_enable_r);
    if (c == ID && lf == 32'h1) chk("leaf1_ecx", {control_register_4[18], 1'b1}, resp_r.ecx[27:26]);
    if (c == ID && lf == 32'hD && sb == 32'h0)
      chk("leafd0", {64'h7, 32'h0340, en_old[2] ? 32'h0340 : 32'h0240}, {resp_r.edx, resp_r.eax, resp_r.ecx, resp_r.ebx});
    if (c == ID && lf == 32'hD && sb == 32'h2) chk("leafd2", {32'h0100, 32'h0240}, {resp_r.eax, resp_r.ebx});
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : run

  task automatic vwr(input logic [3:0] i, input logic w, input logic zu, input logic [255:0] d);
    vreq = {1'b1, w, zu, i, d};
    vm[i] = w ? d : {zu ? 128'h0 : vm[i][255:128], d[127:0]};
    @(negedge clk_sys);
  endtask : vwr

  // The read cycle also ends any write left standing by vwr
  task automatic vrd(input logic [3:0] i);
    vreq.we = 1'b0;
    vreg_rd_idx = i;
    @(negedge clk_sys);
    chk("vreg", vm[i], vreg_rdata_r);
  endtask : vrd

  initial begin
    void'($urandom(49));
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk("enable_reset", 64'h1, state_component_enable_r);
    // Nothing extended is usable until the OS allows it
    run(W128, 64'h0, 32'h0, 32'h0, 1'b0, 192'h0);
    run(WR, 64'h7, 32'h0, 32'h0, 1'b0, 192'h0);
    run(RD, 64'h0, 32'h0, 32'h0, 1'b0, 192'h0);
    run(ID, 64'h0, 32'h1, 32'h0, 1'b0, 192'h0);
    control_register_4 = 32'h0004_0000;
    run(ID, 64'h0, 32'h1, 32'h0, 1'b0, 192'h0);
    run(ID, 64'h0, 32'hD, 32'h2, 1'b0, 192'h0);
    run(wide_vector_state_pkg::CLS_NONE, 64'h7, 32'h0, 32'h0, 1'b0, 192'h0);
    run(W256, 64'h0, 32'h0, 32'h0, 1'b0, 192'h0);
    foreach (wr_tab[k]) begin
      run(WR, wr_tab[k], 32'h0, 32'h0, 1'b0, 192'h0);
      run(ID, 64'h0, 32'hD, 32'h0, 1'b0, 192'h0);
      run(W256, 64'h0, 32'h0, 32'h0, 1'b0, 192'h0);
    end
    // Exception gating across the control bits, wide and narrow alike
    foreach (cr4_tab[k]) begin
      control_register_4 = cr4_tab[k];
      for (int m = 0; m < 6; m++) run(m < 2 ? W256 : (m < 4 ? W128 : NAR), 64'h0, 32'h0, 32'h0, m[0], 192'h0);
    end
    run(SV, {$urandom, $urandom}, 32'h0, 32'h0, 1'b0, 192'h0);
    run(RS, 64'h6, 32'h0, 32'h0, 1'b0, 192'h1);
    run(RS, 64'h8, 32'h0, 32'h0, 1'b0, 192'h0);
    run(RS, 64'h6, 32'h0, 32'h0, 1'b0, 192'h0);
    for (int k = 0; k < 24; k++) run(WR, {$urandom, $urandom} & ($urandom % 2 ? 64'h7 : '1), 32'h0, 32'h0, 1'b0, 192'h0);
    run(WR, 64'h7, 32'h0, 32'h0, 1'b0, 192'h0);
    // Narrow writes must land in the low half of the wide register
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 8; k++) rv = {rv[223:0], $urandom};
      vwr(i[3:0], i < 16, i[4] & i[0], rv);
      if (i > 15) vrd(i[3:0]);
    end
    for (int i = 0; i < 16; i++) begin
      lay_idx = i[3:0];
      @(negedge clk_sys);
      chk("lay_off", 16'(576 + 32 * (i / 2) + 16 * (i % 2)), lay_off_r);
    end
    // A second reset in mid-run must bring the enable register back
    rst = 1'b1;
    en_m = 64'h1;
    @(negedge clk_sys);
    rst = 1'b0;
    run(RD, 64'h0, 32'h0, 32'h0, 1'b0, 192'h0);
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : wide_vector_state_enable_layout_tb
